/* src/nrd_params.svh */
`ifndef NRD_PARAMS_SVH
`define NRD_PARAMS_SVH

// clock and timing
`define NRD_CLK_PERIOD_NS 40
`define NRD_T_LOAD_US     25
`define NRD_LOAD_CYC      ((`NRD_T_LOAD_US * 1000) / `NRD_CLK_PERIOD_NS)
`define NRD_T_RC_NS       25
`define NRD_RC_CYC        ((`NRD_T_RC_NS + `NRD_CLK_PERIOD_NS - 1) / `NRD_CLK_PERIOD_NS)
`define NRD_T_WB_NS       100
`define NRD_WB_CYC        ((`NRD_T_WB_NS + `NRD_CLK_PERIOD_NS - 1) / `NRD_CLK_PERIOD_NS)
`define NRD_RE_LOW_CYC    4

// flash command bytes
`define NRD_CMD_READ      8'h00
`define NRD_CMD_READ_GO   8'h30
`define NRD_CMD_RAND      8'h05
`define NRD_CMD_RAND_GO   8'he0
`define NRD_CMD_STATUS    8'h70
`define NRD_CMD_ID        8'h90
`define NRD_ID_ADDR       8'h00

// byte counts
`define NRD_ID_BYTES      3'h5
`define NRD_PAGE_ADDRS    3'h4
`define NRD_RAND_ADDRS    3'h2

// register byte offsets
`define NRD_OFF_CTRL      8'h00
`define NRD_OFF_COLUMN    8'h04
`define NRD_OFF_ROW       8'h08
`define NRD_OFF_GEOM      8'h0c
`define NRD_OFF_STATUS    8'h10
`define NRD_OFF_DATA      8'h14
`define NRD_OFF_ID0       8'h18
`define NRD_OFF_ID1       8'h1c
`define NRD_OFF_DEC0      8'h20
`define NRD_OFF_DEC1      8'h24

// field positions and reset values
`define NRD_CTRL_CLR_BIT  8
`define NRD_STAT_RDY_BIT  6
`define NRD_RST_GEOM      5'h01
`define NRD_RST_COLUMN    12'h000
`define NRD_RST_ROW       16'h0000

`endif

/* src/nrd_pkg.sv */
package nrd_pkg;

  typedef enum logic [2:0] {OP_NONE, OP_ID, OP_PAGE, OP_RAND, OP_STATUS, OP_DATA} nrd_op_e;
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_READ} nrd_kind_e;
  typedef enum logic [2:0] {ST_IDLE, ST_WB, ST_WAIT, ST_CMD1, ST_ADDR, ST_CMD2, ST_READ} nrd_state_e;
  typedef enum logic [2:0] {PH_IDLE, PH_WLOW, PH_WHIGH, PH_RLOW, PH_RHIGH} nrd_phase_e;

endpackage : nrd_pkg

/* src/nrd_pin_if.sv */
`timescale 1ns/10ps
interface nrd_pin_if;
  import nrd_pkg::*;
  logic      req;
  nrd_kind_e kind;
  logic [7:0] wbyte;
  logic      done;
  logic [7:0] rbyte;
  logic      ready;
  modport ctl (output req, kind, wbyte, input done, rbyte, ready);
  modport phy (input req, kind, wbyte, output done, rbyte, ready);
endinterface : nrd_pin_if

/* src/nrd_pin_seq.sv */
`timescale 1ns/10ps
`include "nrd_params.svh"
module nrd_pin_seq (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // step requests
  nrd_pin_if.phy          pin,
  // flash pins
  input  wire logic       rb_n_i,
  input  wire logic [7:0] io_i,
  output logic            ce_n_o,
  output logic            cle_o,
  output logic            ale_o,
  output logic            we_n_o,
  output logic            re_n_o,
  output logic [7:0]      io_o,
  output logic            io_oe_n_o
);
  import nrd_pkg::*;

  nrd_phase_e phase, next_phase;
  logic [2:0] cnt, next_cnt;
  logic       next_ce_n, next_cle, next_ale, next_we_n, next_re_n, next_oe_n, next_done;
  logic [7:0] next_io, next_rbyte;
  logic       done, rb_s1, rb_s2;
  logic [7:0] rbyte, io_s1, io_s2;

  assign pin.done  = done;
  assign pin.rbyte = rbyte;
  assign pin.ready = rb_s2;

  always_comb begin
    next_phase = phase;
    next_cnt   = cnt;
    next_ce_n  = ce_n_o;
    next_cle   = cle_o;
    next_ale   = ale_o;
    next_we_n  = we_n_o;
    next_re_n  = re_n_o;
    next_io    = io_o;
    next_oe_n  = io_oe_n_o;
    next_done  = 1'b0;
    next_rbyte = rbyte;
    case (phase)
      PH_IDLE: begin
        if (pin.req) begin
          next_ce_n = 1'b0;
          if (pin.kind == K_READ) begin
            next_re_n  = 1'b0;
            next_cnt   = 3'h1;
            next_phase = PH_RLOW;
          end else begin
            // RQ19 latch enable set
            next_cle   = (pin.kind == K_CMD);
            next_ale   = (pin.kind == K_ADDR);
            next_io    = pin.wbyte;
            next_oe_n  = 1'b0;
            next_we_n  = 1'b0;
            next_phase = PH_WLOW;
          end
        end
      end
      PH_WLOW: begin
        // RQ19 rising edge latches
        next_we_n  = 1'b1;
        next_phase = PH_WHIGH;
      end
      PH_WHIGH: begin
        next_cle   = 1'b0;
        next_ale   = 1'b0;
        next_oe_n  = 1'b1;
        next_ce_n  = 1'b1;
        next_done  = 1'b1;
        next_phase = PH_IDLE;
      end
      PH_RLOW: begin
        // RQ11 sample after sync delay
        if (cnt == 3'(`NRD_RE_LOW_CYC)) begin
          next_re_n  = 1'b1;
          next_rbyte = io_s2;
          next_cnt   = 3'h1;
          next_phase = PH_RHIGH;
        end else begin
          next_cnt = cnt + 3'h1;
        end
      end
      PH_RHIGH: begin
        if (cnt >= 3'(`NRD_RC_CYC)) begin
          next_ce_n  = 1'b1;
          next_done  = 1'b1;
          next_phase = PH_IDLE;
        end else begin
          next_cnt = cnt + 3'h1;
        end
      end
      default: next_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase     <= PH_IDLE;
      cnt       <= 3'h0;
      ce_n_o    <= 1'b1;
      cle_o     <= 1'b0;
      ale_o     <= 1'b0;
      we_n_o    <= 1'b1;
      re_n_o    <= 1'b1;
      io_o      <= 8'h00;
      io_oe_n_o <= 1'b1;
      done      <= 1'b0;
      rbyte     <= 8'h00;
      rb_s1     <= 1'b0;
      rb_s2     <= 1'b0;
      io_s1     <= 8'h00;
      io_s2     <= 8'h00;
    end else begin
      phase     <= next_phase;
      cnt       <= next_cnt;
      ce_n_o    <= next_ce_n;
      cle_o     <= next_cle;
      ale_o     <= next_ale;
      we_n_o    <= next_we_n;
      re_n_o    <= next_re_n;
      io_o      <= next_io;
      io_oe_n_o <= next_oe_n;
      done      <= next_done;
      rbyte     <= next_rbyte;
      rb_s1     <= rb_n_i;
      rb_s2     <= rb_s1;
      io_s1     <= io_i;
      io_s2     <= io_s1;
    end
  end

  sequence s_re_low;
    !re_n_o [*4];
  endsequence

  AST_CMD_LATCH: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ19
    $rose(we_n_o) && cle_o |-> !ale_o && !ce_n_o && !io_oe_n_o)
    else $error("command latched without select or drive");
  AST_ADDR_LATCH: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ19
    $fell(we_n_o) |-> (cle_o ^ ale_o) && !ce_n_o ##1 $rose(we_n_o) && (cle_o ^ ale_o))
    else $error("write strobe pulse malformed");
  AST_RE_CYCLE: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RQ11
    $fell(re_n_o) |-> s_re_low ##1 re_n_o && !ce_n_o)
    else $error("read strobe low time wrong");

endmodule : nrd_pin_seq

/* src/nrd_host.sv */
// What this block does
// RQ1: decode chip count and cell type
// RQ2: decode programmed pages, interleave, cache flags
// RQ3: decode page size and block size
// RQ4: decode spare size, width, access time
// RQ5: decode ECC level and plane count
// RQ6: decode plane size, reserved bit zero
// RQ7: first page read may skip 00h
// RQ8: page read is 00h, four addresses, 30h
// RQ9: device loads whole page within 25us
// RQ10: wait for ready before reading data
// RQ11: one byte per read strobe fall
// RQ12: device advances column per strobe
// RQ13: random output repositions column, repeatable
// RQ14: status command allowed right after 30h
// RQ15: address order column low, high, rows
// RQ16: five identification bytes follow 90h
// RQ17: status bit 6 shows ready
// RQ18: reissue 00h after status before data
// RQ19: latch on write strobe rise with enables
// RQ20: check geometry before page reads
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/10ps
`include "nrd_params.svh"
module nrd_host (
  // clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_B_I,
  // ahb-lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic [31:0]      HRDATA_O,
  // flash pins
  output logic             CHIP_SELECT_N_O,
  output logic             COMMAND_LATCH_EN_O,
  output logic             ADDRESS_LATCH_EN_O,
  output logic             WRITE_STROBE_N_O,
  output logic             READ_STROBE_N_O,
  output logic [7:0]       IO_O,
  output logic             IO_OE_N_O,
  input  wire logic [7:0]  IO_I,
  input  wire logic        READY_BUSY_N_I
);
  import nrd_pkg::*;

  nrd_pin_if pin ();

  nrd_pin_seq u_pin (
    .clk_i     (SYS_CLK_I),
    .rst_b_i   (RST_B_I),
    .pin       (pin),
    .rb_n_i    (READY_BUSY_N_I),
    .io_i      (IO_I),
    .ce_n_o    (CHIP_SELECT_N_O),
    .cle_o     (COMMAND_LATCH_EN_O),
    .ale_o     (ADDRESS_LATCH_EN_O),
    .we_n_o    (WRITE_STROBE_N_O),
    .re_n_o    (READ_STROBE_N_O),
    .io_o      (IO_O),
    .io_oe_n_o (IO_OE_N_O)
  );

  nrd_state_e state, next_state;
  nrd_op_e    op, next_op;
  nrd_kind_e  kind, next_kind;
  logic       pend, next_pend, req, next_req;
  logic [7:0] wbyte, next_wbyte, cmd1, next_cmd1, cmd2, next_cmd2;
  logic [2:0] idx, next_idx, naddr, next_naddr, nread, next_nread, addr_cnt, next_addr_cnt;
  logic       cmd1_en, next_cmd1_en, cmd2_en, next_cmd2_en;
  logic [9:0] cnt, next_cnt;
  logic [11:0] column, next_column;
  logic [15:0] row, next_row;
  logic [4:0] geom, next_geom;
  logic [7:0] id_mem [5];
  logic [7:0] next_id_mem [5];
  logic [7:0] status_byte, next_status_byte, data_byte, next_data_byte;
  logic       id_valid, next_id_valid, status_mode, next_status_mode, skip_first, next_skip_first;
  logic       err_to, next_err_to, err_ref, next_err_ref, ready_seen, next_ready_seen;
  logic       a_we, next_a_we;
  logic [7:0] a_off, next_a_off;
  logic [31:0] next_hrdata;
  logic       geom_ok, ap;
  logic [31:0] dec0, dec1;
  logic [5:0] acc_ns;
  logic [2:0] ecc_bits;

  assign pin.req   = req;
  assign pin.kind  = kind;
  assign pin.wbyte = wbyte;
  assign ap        = HSEL_I && HTRANS_I[1] && HREADY_I;

  // RQ20 geometry comparison
  assign geom_ok = id_valid && (id_mem[3][1:0] == geom[1:0]) && (id_mem[3][5:4] == geom[3:2])
                   && (id_mem[3][2] == geom[4]);

  // RQ4 access time code
  always_comb begin
    case ({id_mem[3][7], id_mem[3][3]})
      2'b00:   acc_ns = 6'd45;
      2'b10:   acc_ns = 6'd25;
      default: acc_ns = 6'd0;
    endcase
    // RQ5 ecc level
    case (id_mem[4][1:0])
      2'b00:   ecc_bits = 3'd4;
      2'b01:   ecc_bits = 3'd2;
      2'b10:   ecc_bits = 3'd1;
      default: ecc_bits = 3'd0;
    endcase
  end

  // RQ1 RQ2 RQ3 decoded fields
  assign dec0 = {2'b00, id_mem[3][6], 10'd64 << id_mem[3][5:4], 4'd1 << id_mem[3][1:0], id_mem[2][7],
                 id_mem[2][6], 4'd1 << id_mem[2][5:4], 5'd2 << id_mem[2][3:2], 4'd1 << id_mem[2][1:0]};
  // RQ6 plane size, top bit dropped
  assign dec1 = {14'd64 << id_mem[4][6:4], 4'd1 << id_mem[4][3:2], ecc_bits, acc_ns, 5'd8 << id_mem[3][2]};

  function automatic logic [7:0] addr_byte(input nrd_op_e o, input logic [2:0] i, input logic [11:0] c,
                                           input logic [15:0] r);
    if (o == OP_ID) begin
      addr_byte = `NRD_ID_ADDR;
    end else begin
      // RQ15 column then row
      case (i)
        3'h0:    addr_byte = c[7:0];
        3'h1:    addr_byte = {4'h0, c[11:8]};
        3'h2:    addr_byte = r[7:0];
        default: addr_byte = r[15:8];
      endcase
    end
  endfunction : addr_byte

  always_comb begin
    next_state = state;       next_op = op;             next_kind = kind;
    next_pend = pend;         next_req = 1'b0;          next_wbyte = wbyte;
    next_cmd1 = cmd1;         next_cmd2 = cmd2;         next_idx = idx;
    next_naddr = naddr;       next_nread = nread;       next_addr_cnt = addr_cnt;
    next_cmd1_en = cmd1_en;   next_cmd2_en = cmd2_en;   next_cnt = cnt;
    next_column = column;     next_row = row;           next_geom = geom;
    next_id_mem = id_mem;     next_status_byte = status_byte;
    next_data_byte = data_byte;                          next_id_valid = id_valid;
    next_status_mode = status_mode;                      next_skip_first = skip_first;
    next_err_to = err_to;     next_err_ref = err_ref;   next_ready_seen = ready_seen;
    next_a_we = ap && HWRITE_I;
    next_a_off = ap ? HADDR_I[7:0] : a_off;
    next_hrdata = HRDATA_O;
    // read data registered in address phase so the bus sees zero wait states
    if (ap && !HWRITE_I) begin
      case (HADDR_I[7:0])
        `NRD_OFF_CTRL:   next_hrdata = {29'h0, op};
        `NRD_OFF_COLUMN: next_hrdata = {20'h0, column};
        `NRD_OFF_ROW:    next_hrdata = {16'h0, row};
        `NRD_OFF_GEOM:   next_hrdata = {27'h0, geom};
        `NRD_OFF_STATUS: next_hrdata = {15'h0, status_byte[`NRD_STAT_RDY_BIT], status_byte, skip_first,
                                        err_ref, err_to, id_valid, geom_ok, status_mode, pin.ready,
                                        state != ST_IDLE};
        `NRD_OFF_DATA:   next_hrdata = {24'h0, data_byte};
        `NRD_OFF_ID0:    next_hrdata = {id_mem[3], id_mem[2], id_mem[1], id_mem[0]};
        `NRD_OFF_ID1:    next_hrdata = {24'h0, id_mem[4]};
        `NRD_OFF_DEC0:   next_hrdata = dec0;
        `NRD_OFF_DEC1:   next_hrdata = dec1;
        default:         next_hrdata = 32'h0;
      endcase
    end
    if (a_we) begin
      case (a_off)
        `NRD_OFF_COLUMN: next_column = HWDATA_I[11:0];
        `NRD_OFF_ROW:    next_row = HWDATA_I[15:0];
        `NRD_OFF_GEOM:   next_geom = HWDATA_I[4:0];
        `NRD_OFF_CTRL: begin
          // clears come first so a same-cycle set below wins
          if (HWDATA_I[`NRD_CTRL_CLR_BIT]) begin
            next_err_to  = 1'b0;
            next_err_ref = 1'b0;
          end
          if (state == ST_IDLE && HWDATA_I[2:0] != 3'h0) begin
            next_op = nrd_op_e'(HWDATA_I[2:0]);
            next_idx = 3'h0;          next_cnt = 10'h0;
            next_naddr = 3'h0;        next_nread = 3'h0;
            next_cmd1_en = 1'b1;      next_cmd2_en = 1'b0;
            next_ready_seen = 1'b0;   next_state = ST_CMD1;
            // stale count from an earlier op would skew the confirm checks
            next_addr_cnt = 3'h0;
            case (nrd_op_e'(HWDATA_I[2:0]))
              // RQ16 id command, five bytes
              OP_ID: begin
                next_cmd1 = `NRD_CMD_ID;
                next_naddr = 3'h1;
                next_nread = `NRD_ID_BYTES;
                next_id_valid = 1'b0;
              end
              // RQ8 page read sequence
              OP_PAGE: begin
                next_cmd1 = `NRD_CMD_READ;
                next_naddr = `NRD_PAGE_ADDRS;
                next_cmd2_en = 1'b1;
                next_cmd2 = `NRD_CMD_READ_GO;
                // RQ7 read mode after power-up
                next_cmd1_en = !skip_first;
                // RQ20 refuse on mismatch
                if (!geom_ok) begin
                  next_err_ref = 1'b1;
                  next_state = ST_IDLE;
                end
              end
              // RQ13 random column output
              OP_RAND: begin
                next_cmd1 = `NRD_CMD_RAND;
                next_naddr = `NRD_RAND_ADDRS;
                next_cmd2_en = 1'b1;
                next_cmd2 = `NRD_CMD_RAND_GO;
              end
              // RQ14 status allowed while loading
              OP_STATUS: begin
                next_cmd1 = `NRD_CMD_STATUS;
                next_nread = 3'h1;
              end
              OP_DATA: begin
                // RQ18 leave status output mode
                next_cmd1_en = status_mode;
                next_cmd1 = `NRD_CMD_READ;
                next_nread = 3'h1;
                next_state = ST_WB;
              end
              default: next_state = ST_IDLE;
            endcase
          end
        end
        default: ;
      endcase
    end
    case (state)
      ST_IDLE: ;
      ST_WB: begin
        // device needs time to pull busy low after a confirm
        if (cnt >= 10'(`NRD_WB_CYC)) begin
          next_cnt = 10'h0;
          next_state = ST_WAIT;
        end else begin
          next_cnt = cnt + 10'h1;
        end
      end
      // RQ10 wait for ready
      ST_WAIT: begin
        if (pin.ready) begin
          next_ready_seen = 1'b1;
          next_state = ST_CMD1;
        end else begin
          next_cnt = cnt + 10'h1;
          // RQ9 load overrun flagged, wait continues
          if (cnt == 10'(`NRD_LOAD_CYC)) next_err_to = 1'b1;
        end
      end
      ST_CMD1: begin
        if (!cmd1_en) begin
          next_state = ST_ADDR;
        end else if (!pend) begin
          next_req = 1'b1;  next_pend = 1'b1;
          next_kind = K_CMD;
          next_wbyte = cmd1;
        end else if (pin.done) begin
          next_pend = 1'b0;
          next_skip_first = 1'b0;
          next_addr_cnt = 3'h0;
          if (cmd1 == `NRD_CMD_READ) next_status_mode = 1'b0;
          if (cmd1 == `NRD_CMD_STATUS) next_status_mode = 1'b1;
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (idx == naddr) begin
          next_idx = 3'h0;
          next_state = ST_CMD2;
        end else if (!pend) begin
          next_req = 1'b1;  next_pend = 1'b1;
          next_kind = K_ADDR;
          next_wbyte = addr_byte(op, idx, column, row);
        end else if (pin.done) begin
          next_pend = 1'b0;
          next_idx = idx + 3'h1;
          next_addr_cnt = addr_cnt + 3'h1;
        end
      end
      ST_CMD2: begin
        if (!cmd2_en) begin
          next_state = ST_READ;
        end else if (!pend) begin
          next_req = 1'b1;  next_pend = 1'b1;
          next_kind = K_CMD;
          next_wbyte = cmd2;
        end else if (pin.done) begin
          next_pend = 1'b0;
          next_addr_cnt = 3'h0;
          next_state = ST_READ;
        end
      end
      // RQ11 one strobe per byte
      ST_READ: begin
        if (idx == nread) begin
          next_idx = 3'h0;
          if (op == OP_ID) next_id_valid = 1'b1;
          next_state = ST_IDLE;
        end else if (!pend) begin
          next_req = 1'b1;  next_pend = 1'b1;
          next_kind = K_READ;
        end else if (pin.done) begin
          next_pend = 1'b0;
          next_idx = idx + 3'h1;
          case (op)
            OP_ID:     next_id_mem[idx] = pin.rbyte;
            OP_STATUS: next_status_byte = pin.rbyte;
            default:   next_data_byte = pin.rbyte;
          endcase
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= ST_IDLE;       op <= OP_NONE;        kind <= K_CMD;
      pend <= 1'b0;           req <= 1'b0;          wbyte <= 8'h00;
      cmd1 <= 8'h00;          cmd2 <= 8'h00;        idx <= 3'h0;
      naddr <= 3'h0;          nread <= 3'h0;        addr_cnt <= 3'h0;
      cmd1_en <= 1'b0;        cmd2_en <= 1'b0;      cnt <= 10'h0;
      column <= `NRD_RST_COLUMN;                    row <= `NRD_RST_ROW;
      geom <= `NRD_RST_GEOM;  id_mem <= '{default: 8'h00};
      status_byte <= 8'h00;   data_byte <= 8'h00;   id_valid <= 1'b0;
      status_mode <= 1'b0;    skip_first <= 1'b1;   err_to <= 1'b0;
      err_ref <= 1'b0;        ready_seen <= 1'b0;   a_we <= 1'b0;
      a_off <= 8'h00;         HRDATA_O <= 32'h0;    HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      state <= next_state;    op <= next_op;        kind <= next_kind;
      pend <= next_pend;      req <= next_req;      wbyte <= next_wbyte;
      cmd1 <= next_cmd1;      cmd2 <= next_cmd2;    idx <= next_idx;
      naddr <= next_naddr;    nread <= next_nread;  addr_cnt <= next_addr_cnt;
      cmd1_en <= next_cmd1_en; cmd2_en <= next_cmd2_en; cnt <= next_cnt;
      column <= next_column;  row <= next_row;      geom <= next_geom;
      id_mem <= next_id_mem;  status_byte <= next_status_byte;
      data_byte <= next_data_byte;                  id_valid <= next_id_valid;
      status_mode <= next_status_mode;              skip_first <= next_skip_first;
      err_to <= next_err_to;  err_ref <= next_err_ref;  ready_seen <= next_ready_seen;
      a_we <= next_a_we;      a_off <= next_a_off;  HRDATA_O <= next_hrdata;
      HREADYOUT_O <= 1'b1;    HRESP_O <= 1'b0;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_page_start_skip;
    $fell(state == ST_IDLE) && op == OP_PAGE && !cmd1_en;
  endsequence

  AST_PAGE_CONFIRM: assert property ( // RQ8
    req && kind == K_CMD && wbyte == `NRD_CMD_READ_GO |-> addr_cnt == 3'd4 && op == OP_PAGE)
    else $error("page confirm without four addresses");
  AST_RAND_CONFIRM: assert property ( // RQ13
    req && kind == K_CMD && wbyte == `NRD_CMD_RAND_GO |-> addr_cnt == 3'd2)
    else $error("random output confirm without two addresses");
  AST_DATA_READY: assert property ( // RQ10
    req && kind == K_READ && op == OP_DATA |-> ready_seen)
    else $error("data read before ready");
  AST_STATUS_EXIT: assert property ( // RQ18
    req && kind == K_READ && op == OP_DATA |-> !status_mode)
    else $error("data read while in status mode");
  AST_ADDR_HI: assert property ( // RQ15
    req && kind == K_ADDR && op == OP_PAGE && idx == 3'd1 |-> wbyte[7:4] == 4'h0 && wbyte[3:0] == column[11:8])
    else $error("column high byte wrong");
  AST_GEOM_GATE: assert property ( // RQ20
    $fell(state == ST_IDLE) && op == OP_PAGE |-> geom_ok)
    else $error("page read started without geometry match");
  AST_SKIP_FIRST: assert property ( // RQ7
    s_page_start_skip |-> ##[1:3] (req && kind == K_ADDR))
    else $error("first page read did not go to address");
  AST_LOAD_TIMEOUT: assert property ( // RQ9
    state == ST_WAIT && cnt == 10'd625 && !pin.ready |=> err_to)
    else $error("load overrun not flagged");
  AST_STATUS_MODE: assert property ( // RQ17
    $rose(status_mode) |-> op == OP_STATUS ##[1:12] state == ST_IDLE)
    else $error("status mode entered outside status op");

endmodule : nrd_host

/* testbench/nrd_flash_model.sv */
`timescale 1ns/10ps
module nrd_flash_model #(parameter int LOAD_NS = 4000) (
  input  wire logic       ce_n_i, cle_i, ale_i, we_n_i, re_n_i,
  input  wire logic [7:0] io_i,
  output logic [7:0]      io_o,
  output logic            rb_n_o, seq_err_o
);
  logic [7:0] cmd, q;
  logic [7:0] id [5];
  logic [2:0] na;
  logic [11:0] col;
  logic [15:0] row;
  // bench may stretch the load past the limit
  int load_ns = LOAD_NS;
  initial begin
    id = '{8'h5a, 8'ha5, 8'h80, 8'h95, 8'h40};
    cmd = 8'h00;
    na = 3'h0;
    rb_n_o = 1'b1;
    seq_err_o = 1'b0;
  end
  always @(posedge we_n_i) if (!ce_n_i && cle_i) begin
    if (io_i == 8'h30) begin
      if (cmd != 8'h00 || na != 3'h4) seq_err_o = 1'b1;
      rb_n_o = 1'b0;
      rb_n_o <= #(load_ns) 1'b1;
    end
    if (io_i == 8'h90) col = 12'h000;
    cmd = io_i;
    na = 3'h0;
  end else if (!ce_n_i && ale_i) begin
    case (na)
      3'h0: col[7:0] = io_i;
      3'h1: col[11:8] = io_i[3:0];
      3'h2: row[7:0] = io_i;
      3'h3: row[15:8] = io_i;
      default: ;
    endcase
    na = na + 3'h1;
  end
  always @(negedge re_n_i) if (!ce_n_i) begin
    if (cmd == 8'h70) q = {1'b0, rb_n_o, 6'h00};
    else if (cmd == 8'h90) q = id[col[2:0]];
    else q = col[7:0] ^ row[7:0];
    if (cmd != 8'h70 && col < 12'h83f) col = col + 12'h001;
  end
  // released bus shows inverse, never stale
  assign io_o = (!ce_n_i && !re_n_i) ? q : ~q;
endmodule : nrd_flash_model

/* testbench/nrd_host_tb_top.sv */
`timescale 1ns/10ps
`include "nrd_params.svh"
module nrd_host_tb_top;
  import nrd_pkg::*;
  logic clk, rst_b, hwrite, hready, hresp, cs_n, cle, ale, we_n, re_n, oe_n, rb_n, serr;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] io_o, io_i, fio;
  logic [11:0] cols [2] = '{12'h005, 12'h0ff};
  int failures, num_checks;
  assign io_i = oe_n ? fio : io_o;
  nrd_host DUT (.SYS_CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .HRDATA_O(hrdata), .CHIP_SELECT_N_O(cs_n), .COMMAND_LATCH_EN_O(cle),
    .ADDRESS_LATCH_EN_O(ale), .WRITE_STROBE_N_O(we_n), .READ_STROBE_N_O(re_n), .IO_O(io_o),
    .IO_OE_N_O(oe_n), .IO_I(io_i), .READY_BUSY_N_I(rb_n));
  nrd_flash_model FL (.ce_n_i(cs_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n),
    .io_i(io_i), .io_o(fio), .rb_n_o(rb_n), .seq_err_o(serr));
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rc
  task automatic op(input nrd_op_e o);
    ahb(1'b1, `NRD_OFF_CTRL, {29'h0, o});
    repeat (2) @(posedge clk);
    do ahb(1'b0, `NRD_OFF_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : op
  task automatic t_id;
    rc(`NRD_OFF_STATUS, 32'h81, 32'h80);
    rc(`NRD_OFF_GEOM, 32'h1f, 32'h01);
    op(OP_ID);
    rc(`NRD_OFF_ID0, '1, 32'h9580a55a);
    rc(`NRD_OFF_ID1, 32'hff, 32'h40);
    rc(`NRD_OFF_DEC0, '1, 32'h04014221);
    rc(`NRD_OFF_DEC1, '1, 32'h10006330);
    rc(`NRD_OFF_STATUS, 32'h90, 32'h10);
    op(OP_PAGE);
    rc(`NRD_OFF_STATUS, 32'h40, 32'h40);
    ahb(1'b1, `NRD_OFF_CTRL, 32'h100);
    repeat (2) @(posedge clk);
    rc(`NRD_OFF_STATUS, 32'h60, 32'h0);
  endtask : t_id
  task automatic t_page;
    ahb(1'b1, `NRD_OFF_GEOM, 32'h15);
    ahb(1'b1, `NRD_OFF_COLUMN, 32'h83e);
    ahb(1'b1, `NRD_OFF_ROW, 32'h1234);
    op(OP_PAGE);
    rc(`NRD_OFF_STATUS, 32'h62, 32'h0);
    op(OP_DATA);
    rc(`NRD_OFF_DATA, 32'hff, 32'h0a);
    op(OP_DATA);
    rc(`NRD_OFF_DATA, 32'hff, 32'h0b);
    ahb(1'b1, `NRD_OFF_COLUMN, 32'h10);
    op(OP_PAGE);
    op(OP_STATUS);
    rc(`NRD_OFF_STATUS, 32'h10004, 32'h4);
    op(OP_DATA);
    rc(`NRD_OFF_DATA, 32'hff, 32'h24);
  endtask : t_page
  task automatic t_rand;
    foreach (cols[i]) begin
      ahb(1'b1, `NRD_OFF_COLUMN, {20'h0, cols[i]});
      op(OP_RAND);
      for (int k = 0; k < 2; k++) begin
        op(OP_DATA);
        rc(`NRD_OFF_DATA, 32'hff, {24'h0, 8'(cols[i] + k) ^ 8'h34});
      end
    end
    FL.load_ns = 30000;
    op(OP_PAGE);
    op(OP_DATA);
    rc(`NRD_OFF_STATUS, 32'h20, 32'h20);
    rc(`NRD_OFF_DATA, 32'hff, 32'hcb);
    op(OP_STATUS);
    rc(`NRD_OFF_STATUS, 32'h10000, 32'h10000);
    op(OP_DATA);
    rc(`NRD_OFF_DATA, 32'hff, 32'h34);
    ahb(1'b1, 8'h40, '1);
    rc(8'h40, '1, 32'h0);
    rc(`NRD_OFF_CTRL, 32'h7, 32'h5);
    chk({30'h0, hresp, serr}, 32'h0);
  endtask : t_rand
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    failures++;
    end_sim;
  end
  initial begin
    {rst_b, hwrite, htrans, haddr, hwdata} = '0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_id;
    t_page;
    t_rand;
    end_sim;
  end
endmodule : nrd_host_tb_top
